// file: stack_unit_consts.svh
// constants of the stack push and pop unit
`ifndef STACK_UNIT_CONSTS_SVH
`define STACK_UNIT_CONSTS_SVH

// register codes on the register select input
`define RC_DATA_FIRST 6'h00
`define RC_DATA_LAST 6'h07
`define RC_PTR_FIRST 6'h08
`define RC_PTR_LAST 6'h0d
`define RC_SP 6'h0e
`define RC_FP 6'h0f
`define RC_ADDR_FIRST 6'h10
`define RC_ADDR_LAST 6'h1f
`define RC_ACC_FIRST 6'h20
`define RC_ACC_LAST 6'h23
`define RC_ARITH 6'h24
`define RC_RET_SUB 6'h25
`define RC_RET_INT 6'h26
`define RC_RET_EXC 6'h27
`define RC_RET_NMI 6'h28
`define RC_RET_EMU 6'h29
`define RC_LOOP_FIRST 6'h2a
`define RC_LOOP_LAST 6'h2f
`define RC_CYC_LO 6'h30
`define RC_CYC_HI 6'h31
`define RC_EMU_DATA 6'h32
`define RC_USP 6'h33
`define RC_SEQ 6'h34
`define RC_SYSTEM_CONFIG_REG 6'h35
`define RC_COUNT 54

// stack geometry
`define WORD_BYTES 32'h00000004
`define ALIGN_OK 2'h0
`define DATA_LO_MAX 3'h7
`define PTR_LO_MAX 3'h5
`define SP_RESET 32'h00000000
`define FLAGS_RESET 32'h00000000

`endif

// file: stack_unit_pkg.sv
// types of the stack push and pop unit
package stack_unit_pkg;
  typedef enum logic [1:0] {OP_PUSH, OP_PUSH_MULTI, OP_POP, OP_NONE} op_t;
  typedef enum logic [2:0] {
    EXC_NONE, EXC_UNDEF, EXC_PROT, EXC_ALIGN, EXC_MEM
  } exc_t;
endpackage : stack_unit_pkg

// file: regfile_if.sv
// register file access between the sequencer and its storage
interface regfile_if;
  logic rd_en;
  logic [5:0] rd_idx;
  logic [31:0] rd_data;
  logic wr_en;
  logic [5:0] wr_idx;
  logic [31:0] wr_data;
  modport ctrl(output rd_en, rd_idx, wr_en, wr_idx, wr_data,
               input rd_data);
  modport store(input rd_en, rd_idx, wr_en, wr_idx, wr_data,
                output rd_data);
endinterface : regfile_if

// file: stack_reg_mem.sv
// core register storage with registered read data
`include "stack_unit_consts.svh"
module stack_reg_mem #(
  parameter int DEPTH = 64
) (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  regfile_if.store rf
);
  logic [31:0] mem [DEPTH];

  if (DEPTH > 64 || DEPTH < `RC_COUNT) begin : g_chk
    $error("stack_reg_mem: DEPTH out of range");
  end

  always_ff @(posedge ref_clk_i) begin
    if (rf.wr_en) begin
      mem[rf.wr_idx] <= rf.wr_data;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      rf.rd_data <= 32'h00000000;
    end else if (rf.rd_en) begin
      rf.rd_data <= mem[rf.rd_idx];
    end
  end
endmodule : stack_reg_mem

// file: stack_access_check.sv
// decode checks that decide whether a stack instruction may run
`include "stack_unit_consts.svh"
module stack_access_check
  import stack_unit_pkg::*;
(
  input wire op_t op_i,
  input wire logic [5:0] reg_code_i,
  input wire logic data_en_i,
  input wire logic ptr_en_i,
  input wire logic [2:0] ptr_lo_i,
  input wire logic parallel_i,
  input wire logic user_mode_i,
  input wire logic [1:0] sp_low_i,
  output exc_t cause_o
);
  function automatic logic in_range(input logic [5:0] c,
                                    input logic [5:0] lo,
                                    input logic [5:0] hi);
    return (c >= lo) && (c <= hi);
  endfunction : in_range

  function automatic logic is_priv(input logic [5:0] c);
    return (c == `RC_USP) || (c == `RC_SEQ) || (c == `RC_SYSTEM_CONFIG_REG) ||
           in_range(c, `RC_RET_INT, `RC_RET_EMU);
  endfunction : is_priv

  logic push_ok;
  logic pop_ok;
  logic multi_ok;

  // push set excludes the stack pointer; pop also rejects the cycle counters and the emulation data register
  always_comb begin
    push_ok = in_range(reg_code_i, `RC_DATA_FIRST, `RC_SYSTEM_CONFIG_REG) &&
              (reg_code_i != `RC_SP);
    pop_ok = push_ok && (reg_code_i != `RC_CYC_LO) &&
             (reg_code_i != `RC_CYC_HI) &&
             (reg_code_i != `RC_EMU_DATA);
    multi_ok = (data_en_i || ptr_en_i) &&
               (!ptr_en_i || ptr_lo_i <= `PTR_LO_MAX);
  end

  always_comb begin
    cause_o = EXC_NONE;
    if (parallel_i || op_i == OP_NONE) begin
      cause_o = EXC_UNDEF;
    end else if (op_i == OP_POP && reg_code_i == `RC_SP) begin
      cause_o = EXC_UNDEF;
    end else if ((op_i == OP_PUSH && !push_ok) ||
                 (op_i == OP_POP && !pop_ok) ||
                 (op_i == OP_PUSH_MULTI && !multi_ok)) begin
      cause_o = EXC_UNDEF;
    end else if (op_i != OP_PUSH_MULTI && user_mode_i &&
                 is_priv(reg_code_i)) begin
      cause_o = EXC_PROT;
    end else if (sp_low_i != `ALIGN_OK) begin
      cause_o = EXC_ALIGN;
    end
  end
endmodule : stack_access_check

// file: stack_push_pop_unit.sv
// stack push, push multiple and pop sequencer of the core
`include "stack_unit_consts.svh"

module stack_push_pop_unit
  import stack_unit_pkg::*;
#(
  parameter int REG_DEPTH = 64
) (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic issue_valid_i,
  input wire op_t op_i,
  input wire logic [5:0] reg_code_i,
  input wire logic data_en_i,
  input wire logic [2:0] data_lo_i,
  input wire logic ptr_en_i,
  input wire logic [2:0] ptr_lo_i,
  input wire logic parallel_i,
  input wire logic user_mode_i,
  output logic issue_ready_o,
  output logic done_o,
  output logic exc_o,
  output exc_t exc_cause_o,
  output logic mem_req_o,
  output logic mem_we_o,
  output logic [31:0] mem_addr_o,
  output logic [31:0] mem_wdata_o,
  input wire logic mem_ack_i,
  input wire logic mem_err_i,
  input wire logic [31:0] mem_rdata_i,
  input wire logic irq_pending_i,
  output logic irq_take_o,
  output logic irq_enable_o,
  output logic [31:0] stack_pointer_o,
  output logic [31:0] arith_flags_o,
  input wire logic reg_load_i,
  input wire logic [5:0] reg_load_idx_i,
  input wire logic [31:0] reg_load_data_i,
  output logic loaded_o,
  output logic [5:0] loaded_idx_o,
  output logic [31:0] loaded_data_o
);
  typedef enum logic [1:0] {ST_IDLE, ST_FETCH, ST_STORE, ST_LOAD} state_t;

  if (REG_DEPTH < `RC_COUNT || REG_DEPTH > 64) begin : g_chk
    $error("stack_push_pop_unit: REG_DEPTH out of range");
  end

  // first register of a multi push: lowest selected data or pointer
  function automatic logic [5:0] first_multi(input logic d_en,
                                             input logic [2:0] d_lo,
                                             input logic [2:0] p_lo);
    if (d_en) begin
      return {3'h0, d_lo};
    end
    return `RC_PTR_FIRST + {3'h0, p_lo};
  endfunction : first_multi

  // step to next register: data up to top, then pointers
  function automatic logic [5:0] next_multi(input logic [5:0] cur,
                                            input logic [2:0] p_lo);
    if (cur == `RC_DATA_LAST) begin
      return `RC_PTR_FIRST + {3'h0, p_lo};
    end
    return cur + 6'h01;
  endfunction : next_multi

  // the range always ends at the top data or top pointer register
  function automatic logic multi_more(input logic [5:0] cur,
                                      input logic p_en);
    return !((cur == `RC_PTR_LAST) ||
             (cur == `RC_DATA_LAST && !p_en));
  endfunction : multi_more

  state_t state_reg;
  op_t op_reg;
  logic [5:0] cur_reg;
  logic ptr_en_reg;
  logic [2:0] ptr_lo_reg;
  logic [31:0] sp_reg;
  logic [31:0] sp_start_reg;
  logic hold_reg;
  logic irq_en_reg;
  logic [31:0] flags_reg;
  logic done_reg;
  logic exc_reg;
  exc_t cause_reg;
  logic req_reg;
  logic we_reg;
  logic [31:0] addr_reg;
  logic [31:0] wdata_reg;
  logic loaded_reg;
  logic [5:0] loaded_idx_reg;
  logic [31:0] loaded_data_reg;
  exc_t check_cause;
  logic accept;
  logic reject;
  logic store_ack;
  logic load_ack;
  logic mem_fault;
  logic more;

  regfile_if rf ();

  stack_access_check u_check (
    .op_i(op_i),
    .reg_code_i(reg_code_i),
    .data_en_i(data_en_i),
    .ptr_en_i(ptr_en_i),
    .ptr_lo_i(ptr_lo_i),
    .parallel_i(parallel_i),
    .user_mode_i(user_mode_i),
    .sp_low_i(sp_reg[1:0]),
    .cause_o(check_cause)
  );

  stack_reg_mem #(
    .DEPTH(REG_DEPTH)
  ) u_regs (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .rf(rf)
  );

  always_comb begin
    accept = (state_reg == ST_IDLE) && issue_valid_i &&
             (check_cause == EXC_NONE);
    reject = (state_reg == ST_IDLE) && issue_valid_i &&
             (check_cause != EXC_NONE);
    store_ack = (state_reg == ST_STORE) && mem_ack_i && !mem_err_i;
    load_ack = (state_reg == ST_LOAD) && mem_ack_i && !mem_err_i;
    mem_fault = (state_reg == ST_STORE || state_reg == ST_LOAD) &&
                mem_err_i;
    more = (op_reg == OP_PUSH_MULTI) && multi_more(cur_reg, ptr_en_reg);
  end

  // register file reads feed stores, writes take pops and loads
  always_comb begin
    rf.rd_en = 1'b0;
    rf.rd_idx = cur_reg;
    if (accept && op_i == OP_PUSH) begin
      rf.rd_en = 1'b1;
      rf.rd_idx = reg_code_i;
    end else if (accept && op_i == OP_PUSH_MULTI) begin
      rf.rd_en = 1'b1;
      rf.rd_idx = first_multi(data_en_i, data_lo_i, ptr_lo_i);
    end else if (store_ack && more) begin
      rf.rd_en = 1'b1;
      rf.rd_idx = next_multi(cur_reg, ptr_lo_reg);
    end
    rf.wr_en = load_ack ||
               ((state_reg == ST_IDLE) && !issue_valid_i && reg_load_i);
    rf.wr_idx = load_ack ? cur_reg : reg_load_idx_i;
    rf.wr_data = load_ack ? mem_rdata_i : reg_load_data_i;
  end

  // sequencing
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      state_reg <= ST_IDLE;
      op_reg <= OP_PUSH;
      cur_reg <= 6'h00;
      ptr_en_reg <= 1'b0;
      ptr_lo_reg <= 3'h0;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (accept) begin
            op_reg <= op_i;
            ptr_en_reg <= ptr_en_i;
            ptr_lo_reg <= ptr_lo_i;
            cur_reg <= rf.rd_idx;
            if (op_i == OP_POP) begin
              cur_reg <= reg_code_i;
              state_reg <= ST_LOAD;
            end else begin
              state_reg <= ST_FETCH;
            end
          end
        end
        ST_FETCH: begin
          state_reg <= ST_STORE;
        end
        ST_STORE: begin
          if (mem_fault) begin
            state_reg <= ST_IDLE;
          end else if (store_ack && more) begin
            cur_reg <= rf.rd_idx;
            state_reg <= ST_FETCH;
          end else if (store_ack) begin
            state_reg <= ST_IDLE;
          end
        end
        ST_LOAD: begin
          if (mem_fault || load_ack) begin
            state_reg <= ST_IDLE;
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // stack pointer: pre-decrement per store, post-increment per pop
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      sp_reg <= `SP_RESET;
      sp_start_reg <= `SP_RESET;
    end else begin
      if (accept) begin
        sp_start_reg <= sp_reg;
      end
      if (mem_fault) begin
        sp_reg <= sp_start_reg;
      end else if (state_reg == ST_FETCH) begin
        sp_reg <= sp_reg - `WORD_BYTES;
      end else if (load_ack) begin
        sp_reg <= sp_reg + `WORD_BYTES;
      end
    end
  end

  // memory request: stores below the pointer, loads at it
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      req_reg <= 1'b0;
      we_reg <= 1'b0;
      addr_reg <= 32'h00000000;
      wdata_reg <= 32'h00000000;
    end else begin
      if (accept && op_i == OP_POP) begin
        req_reg <= 1'b1;
        we_reg <= 1'b0;
        addr_reg <= sp_reg;
      end else if (state_reg == ST_FETCH) begin
        req_reg <= 1'b1;
        we_reg <= 1'b1;
        addr_reg <= sp_reg - `WORD_BYTES;
        wdata_reg <= rf.rd_data;
      end else if (mem_fault || store_ack || load_ack) begin
        req_reg <= 1'b0;
        we_reg <= 1'b0;
      end
    end
  end

  // interrupt system state and hold-off during multi push
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      hold_reg <= 1'b0;
      irq_en_reg <= 1'b0;
    end else begin
      if (state_reg == ST_FETCH && op_reg == OP_PUSH_MULTI) begin
        hold_reg <= 1'b1;
      end else if (mem_fault || (store_ack && !more)) begin
        hold_reg <= 1'b0;
      end
      // subroutine return touches nothing here
      if (store_ack && op_reg == OP_PUSH && cur_reg == `RC_RET_INT) begin
        irq_en_reg <= 1'b1;
      end else if (load_ack && cur_reg == `RC_RET_INT) begin
        irq_en_reg <= 1'b0;
      end
    end
  end

  // arithmetic flags change only on a pop into the status register
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      flags_reg <= `FLAGS_RESET;
    end else if (load_ack && cur_reg == `RC_ARITH) begin
      flags_reg <= mem_rdata_i;
    end
  end

  // completion and exception reporting
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      done_reg <= 1'b0;
      exc_reg <= 1'b0;
      cause_reg <= EXC_NONE;
    end else begin
      done_reg <= (store_ack && !more) || load_ack;
      exc_reg <= reject || mem_fault;
      if (reject) begin
        cause_reg <= check_cause;
      end else if (mem_fault) begin
        cause_reg <= EXC_MEM;
      end
    end
  end

  // mirror of register writes made by pops
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      loaded_reg <= 1'b0;
      loaded_idx_reg <= 6'h00;
      loaded_data_reg <= 32'h00000000;
    end else begin
      loaded_reg <= load_ack;
      if (load_ack) begin
        loaded_idx_reg <= cur_reg;
        loaded_data_reg <= mem_rdata_i;
      end
    end
  end

  assign issue_ready_o = (state_reg == ST_IDLE);
  assign irq_take_o = irq_pending_i && irq_en_reg && !hold_reg;
  assign irq_enable_o = irq_en_reg;
  assign done_o = done_reg;
  assign exc_o = exc_reg;
  assign exc_cause_o = cause_reg;
  assign mem_req_o = req_reg;
  assign mem_we_o = we_reg;
  assign mem_addr_o = addr_reg;
  assign mem_wdata_o = wdata_reg;
  assign stack_pointer_o = sp_reg;
  assign arith_flags_o = flags_reg;
  assign loaded_o = loaded_reg;
  assign loaded_idx_o = loaded_idx_reg;
  assign loaded_data_o = loaded_data_reg;
endmodule : stack_push_pop_unit

// file: stack_unit_monitor.sv
// port checker for the stack push and pop unit
`include "stack_unit_consts.svh"
module stack_unit_monitor
  import stack_unit_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic issue_valid_i,
  input wire logic issue_ready_o,
  input wire op_t op_i,
  input wire logic [5:0] reg_code_i,
  input wire logic parallel_i,
  input wire logic user_mode_i,
  input wire logic done_o,
  input wire logic exc_o,
  input wire exc_t exc_cause_o,
  input wire logic mem_req_o,
  input wire logic mem_we_o,
  input wire logic [31:0] mem_addr_o,
  input wire logic mem_ack_i,
  input wire logic mem_err_i,
  input wire logic irq_take_o,
  input wire logic irq_enable_o,
  input wire logic [31:0] stack_pointer_o,
  input wire logic [31:0] arith_flags_o
);
  logic take;
  op_t op_reg;
  logic [5:0] code_reg;
  logic [31:0] sp_reg;
  assign take = issue_valid_i && issue_ready_o;
  // remember the instruction in flight and its starting pointer
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      op_reg <= OP_NONE;
      code_reg <= 6'h00;
      sp_reg <= 32'h00000000;
    end else if (take) begin
      op_reg <= op_i;
      code_reg <= reg_code_i;
      sp_reg <= stack_pointer_o;
    end
  end
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  sequence s_multi_end;
    ##[0:300] (done_o || exc_o);
  endsequence
  sequence s_store_open;
    $rose(mem_req_o) && mem_we_o;
  endsequence
  a_req_held:
  assert property (mem_req_o && !mem_ack_i && !mem_err_i |=>
    mem_req_o && $stable(mem_addr_o) && $stable(mem_we_o))
    else $error("memory request changed before its answer");
  a_push_addr:
  assert property (op_reg == OP_PUSH && $rose(mem_req_o) |->
    s_store_open ##0 mem_addr_o == sp_reg - `WORD_BYTES)
    else $error("push store not one word below pointer");
  a_multi_step:
  assert property (op_reg == OP_PUSH_MULTI && $rose(mem_req_o) |->
    s_store_open ##0 mem_addr_o == stack_pointer_o)
    else $error("multi store not at decremented pointer");
  a_pop_read:
  assert property (op_reg == OP_POP && mem_req_o |->
    !mem_we_o && mem_addr_o == sp_reg)
    else $error("pop access not a load at the pointer");
  a_pop_adv:
  assert property (op_reg == OP_POP && done_o |->
    stack_pointer_o == sp_reg + `WORD_BYTES)
    else $error("pop did not advance pointer one word");
  a_irq_held:
  assert property (op_reg == OP_PUSH_MULTI && $rose(mem_req_o) |->
    (!irq_take_o || done_o || exc_o) throughout s_multi_end)
    else $error("interrupt taken inside multi push");
  a_err_restore:
  assert property (op_reg == OP_PUSH_MULTI && mem_req_o && mem_err_i |->
    ##[1:2] (exc_o && stack_pointer_o == sp_reg))
    else $error("aborted multi push kept a moved pointer");
  a_undef_issue:
  assert property (take && (parallel_i ||
    (op_i == OP_POP && reg_code_i == `RC_SP)) |=>
    exc_o && exc_cause_o == EXC_UNDEF && !mem_req_o)
    else $error("undefined stack instruction not refused");
  a_user_prot:
  assert property (take && user_mode_i && !parallel_i &&
    (op_i == OP_PUSH || op_i == OP_POP) && reg_code_i inside
    {[`RC_RET_INT:`RC_RET_EMU], [`RC_USP:`RC_SYSTEM_CONFIG_REG]} |=>
    exc_o && exc_cause_o == EXC_PROT)
    else $error("user access to privileged register not refused");
  a_irq_change:
  assert property ($changed(irq_enable_o) |-> done_o &&
    code_reg == `RC_RET_INT && (op_reg == OP_PUSH) == irq_enable_o)
    else $error("interrupt enable moved without its register");
  a_flags_only:
  assert property ($changed(arith_flags_o) |->
    done_o && op_reg == OP_POP && code_reg == `RC_ARITH)
    else $error("flags changed outside a status pop");
endmodule : stack_unit_monitor

// file: stack_mem_model.sv
// data memory model on the far side of the load and store path
module stack_mem_model (
  input wire logic ref_clk_i,
  input wire logic req_i,
  input wire logic we_i,
  input wire logic [31:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic [7:0] lat_i,
  input wire logic [7:0] err_at_i,
  output logic ack_o = 1'b0,
  output logic err_o = 1'b0,
  output logic [31:0] rdata_o = 32'h00000000
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] mem [logic [31:0]];
  logic [7:0] wait_cnt = 8'h00;
  logic [7:0] n_acc = 8'h00;
  always @(posedge ref_clk_i) begin
    ack_o <= 1'b0;
    err_o <= 1'b0;
    rdata_o <= ~rdata_o;
    if (req_i && !ack_o && !err_o) begin
      if (wait_cnt < lat_i) begin
        wait_cnt <= wait_cnt + 8'h01;
      end else begin
        wait_cnt <= 8'h00;
        n_acc <= n_acc + 8'h01;
        if (n_acc + 8'h01 == err_at_i) begin
          err_o <= 1'b1;
        end else begin
          ack_o <= 1'b1;
          if (we_i) begin
            mem[addr_i] = wdata_i;
          end else begin
            rdata_o <= mem.exists(addr_i) ? mem[addr_i] : 32'h00000000;
          end
        end
      end
    end
  end
endmodule : stack_mem_model

// file: tb_top.sv
// testbench for the stack push and pop unit
`include "stack_unit_consts.svh"
module tb_top
  import stack_unit_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst_n, valid, de, pe, par, um, irq, ld, ready, done, exc;
  logic req, we, ack, err, take, irq_en, saw_take, lv;
  op_t op;
  exc_t cause;
  logic [5:0] code, ld_idx, lidx;
  logic [2:0] dl, pl;
  logic [7:0] lat, err_at;
  logic [31:0] ld_data, addr, wdata, rdata, sp, flags, s, ldat;
  int num_errors = 0;
  int checked = 0;
  stack_push_pop_unit u_stack_push_pop_unit (
    .ref_clk_i(clk), .rst_n_i(rst_n), .issue_valid_i(valid), .op_i(op),
    .reg_code_i(code), .data_en_i(de), .data_lo_i(dl), .ptr_en_i(pe),
    .ptr_lo_i(pl), .parallel_i(par), .user_mode_i(um),
    .issue_ready_o(ready), .done_o(done), .exc_o(exc),
    .exc_cause_o(cause), .mem_req_o(req), .mem_we_o(we),
    .mem_addr_o(addr), .mem_wdata_o(wdata), .mem_ack_i(ack),
    .mem_err_i(err), .mem_rdata_i(rdata), .irq_pending_i(irq),
    .irq_take_o(take), .irq_enable_o(irq_en), .stack_pointer_o(sp),
    .arith_flags_o(flags), .reg_load_i(ld), .reg_load_idx_i(ld_idx),
    .reg_load_data_i(ld_data), .loaded_o(lv), .loaded_idx_o(lidx),
    .loaded_data_o(ldat));
  stack_mem_model u_stack_mem_model (.ref_clk_i(clk), .req_i(req),
    .we_i(we), .addr_i(addr), .wdata_i(wdata), .lat_i(lat),
    .err_at_i(err_at), .ack_o(ack), .err_o(err), .rdata_o(rdata));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  function automatic logic [31:0] mw(input logic [31:0] a);
    return u_stack_mem_model.mem[a];
  endfunction : mw
  task automatic chk(input string what, input logic [31:0] seen,
                     input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic load(input logic [5:0] i, input logic [31:0] d);
    @(negedge clk);
    ld = 1'b1;
    ld_idx = i;
    ld_data = d;
    @(negedge clk);
    ld = 1'b0;
  endtask : load
  // issue one instruction and wait for its completion or exception
  task automatic go(input op_t o, input logic [5:0] c, input logic d_en,
                    input logic [2:0] d_lo, input logic p_en,
                    input logic [2:0] p_lo, input logic pa, input logic u);
    int n;
    @(negedge clk);
    op = o;
    code = c;
    de = d_en;
    dl = d_lo;
    pe = p_en;
    pl = p_lo;
    par = pa;
    um = u;
    valid = 1'b1;
    n = 0;
    while (!ready && n < 50) begin
      @(negedge clk);
      n++;
    end
    @(negedge clk);
    valid = 1'b0;
    while (done !== 1'b1 && exc !== 1'b1 && n < 400) begin
      saw_take |= take && req;
      @(negedge clk);
      n++;
    end
  endtask : go
  task automatic refuse(input op_t o, input logic [5:0] c, input logic p,
                        input logic pa, input logic u, input exc_t e);
    s = sp;
    go(o, c, 1'b0, 3'h0, p, 3'h6, pa, u);
    chk("refused exc", exc, 1'b1);
    chk("refused cause", cause, e);
    chk("refused sp", sp, s);
  endtask : refuse
  task automatic t_push;
    load(6'h03, 32'h00c0ffee);
    go(OP_PUSH, 6'h03, 1'b0, 3'h0, 1'b0, 3'h0, 1'b0, 1'b0);
    chk("push done", done, 1'b1);
    chk("push sp", sp, 32'hfffffffc);
    chk("push word", mw(32'hfffffffc), 32'h00c0ffee);
    $display("test push finished");
  endtask : t_push
  task automatic t_multi;
    lat = 8'h02;
    go(OP_PUSH, `RC_RET_INT, 1'b0, 3'h0, 1'b0, 3'h0, 1'b0, 1'b0);
    chk("irq enable", irq_en, 1'b1);
    for (int i = 5; i < 8; i++) load(6'(i), 32'h0000a000 + i);
    for (int j = 4; j < 6; j++) load(6'(8 + j), 32'h0000b000 + j);
    s = sp;
    saw_take = 1'b0;
    // scratch values kept in low registers are stored first
    go(OP_PUSH_MULTI, 6'h00, 1'b1, 3'h5, 1'b1, 3'h4, 1'b0, 1'b0);
    for (int k = 0; k < 5; k++) begin
      chk("multi word", mw(s - 4 * (k + 1)),
          k < 3 ? 32'h0000a005 + k : 32'h0000b001 + k);
    end
    chk("multi sp", sp, s - 32'h14);
    chk("multi irq held", saw_take, 1'b0);
    chk("irq take after", take, 1'b1);
    $display("test multi push finished");
  endtask : t_multi
  task automatic t_pop;
    lat = 8'h00;
    s = sp;
    go(OP_POP, `RC_ARITH, 1'b0, 3'h0, 1'b0, 3'h0, 1'b0, 1'b0);
    chk("pop flags", flags, 32'h0000b005);
    chk("pop loaded", lv, 1'b1);
    chk("pop loaded idx", lidx, `RC_ARITH);
    chk("pop loaded data", ldat, 32'h0000b005);
    chk("pop sp", sp, s + 32'h4);
    chk("pop word kept", mw(s), 32'h0000b005);
    go(OP_POP, `RC_RET_SUB, 1'b0, 3'h0, 1'b0, 3'h0, 1'b0, 1'b0);
    chk("sub pop irq", irq_en, 1'b1);
    chk("sub pop flags", flags, 32'h0000b005);
    go(OP_POP, `RC_RET_INT, 1'b0, 3'h0, 1'b0, 3'h0, 1'b0, 1'b0);
    chk("int pop irq", irq_en, 1'b0);
    go(OP_PUSH, `RC_RET_SUB, 1'b0, 3'h0, 1'b0, 3'h0, 1'b0, 1'b0);
    chk("sub push irq", irq_en, 1'b0);
    $display("test pop finished");
  endtask : t_pop
  task automatic t_refuse;
    refuse(OP_POP, `RC_SP, 1'b0, 1'b0, 1'b0, EXC_UNDEF);
    refuse(OP_PUSH, 6'h03, 1'b0, 1'b1, 1'b0, EXC_UNDEF);
    refuse(OP_POP, `RC_SEQ, 1'b0, 1'b0, 1'b1, EXC_PROT);
    refuse(OP_PUSH, `RC_USP, 1'b0, 1'b0, 1'b1, EXC_PROT);
    refuse(OP_PUSH_MULTI, 6'h00, 1'b1, 1'b0, 1'b0, EXC_UNDEF);
    refuse(OP_POP, `RC_CYC_LO, 1'b0, 1'b0, 1'b0, EXC_UNDEF);
    refuse(OP_NONE, 6'h03, 1'b0, 1'b0, 1'b0, EXC_UNDEF);
    refuse(OP_PUSH_MULTI, 6'h00, 1'b0, 1'b0, 1'b0, EXC_UNDEF);
    $display("test refusals finished");
  endtask : t_refuse
  task automatic t_abort;
    lat = 8'h01;
    for (int i = 0; i < 8; i++) load(6'(i), 32'h0000c000 + i);
    err_at = u_stack_mem_model.n_acc + 8'h03;
    s = sp;
    go(OP_PUSH_MULTI, 6'h00, 1'b1, 3'h0, 1'b0, 3'h5, 1'b0, 1'b0);
    chk("abort cause", cause, EXC_MEM);
    chk("abort sp", sp, s);
    chk("abort kept 0", mw(s - 32'h4), 32'h0000c000);
    chk("abort kept 1", mw(s - 32'h8), 32'h0000c001);
    err_at = 8'h00;
    $display("test abort finished");
  endtask : t_abort
  task automatic test_done;
    $display("checks %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : test_done
  initial begin
    {rst_n, valid, de, pe, par, um, irq, ld, saw_take} = 9'h000;
    op = OP_NONE;
    {code, ld_idx, dl, pl} = 18'h00000;
    {lat, err_at} = 16'h0000;
    ld_data = 32'h00000000;
    repeat (20) @(negedge clk);
    rst_n = 1'b1;
    irq = 1'b1;
    t_push();
    t_multi();
    t_pop();
    t_refuse();
    t_abort();
    test_done();
  end
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    $display("unexpected watchdog: expected finish seen timeout");
    test_done();
  end
endmodule : tb_top
bind stack_push_pop_unit stack_unit_monitor u_stack_unit_monitor (
  .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
  .issue_valid_i(issue_valid_i), .issue_ready_o(issue_ready_o),
  .op_i(op_i), .reg_code_i(reg_code_i), .parallel_i(parallel_i),
  .user_mode_i(user_mode_i), .done_o(done_o), .exc_o(exc_o),
  .exc_cause_o(exc_cause_o), .mem_req_o(mem_req_o),
  .mem_we_o(mem_we_o), .mem_addr_o(mem_addr_o),
  .mem_ack_i(mem_ack_i), .mem_err_i(mem_err_i),
  .irq_take_o(irq_take_o), .irq_enable_o(irq_enable_o),
  .stack_pointer_o(stack_pointer_o), .arith_flags_o(arith_flags_o));
